// ### cml_pkg.sv
package cml_pkg;

   ////////////////////////////////////////////////////////////////////
   // Clock rates and derived cycle counts
   localparam int MCLK_HZ       = 10_000_000;
   localparam int CONFIG_CLOCK_SLOW_HZ  = 1_000_000;
   localparam int CONFIG_CLOCK_HALF_CYC = MCLK_HZ / (2 * CONFIG_CLOCK_SLOW_HZ);
   localparam int XPR_MAX_HZ    = 10_000_000;

   ////////////////////////////////////////////////////////////////////
   // Mode codes, {mode_select_2, mode_select_1, mode_select_0}
   localparam logic [2:0] MODE_MSER = 3'h0;
   localparam logic [2:0] MODE_SSER = 3'h7;
   localparam logic [2:0] MODE_MPUP = 3'h4;
   localparam logic [2:0] MODE_MPDN = 3'h6;
   localparam logic [2:0] MODE_SPER = 3'h3;
   localparam logic [2:0] MODE_APER = 3'h5;
   localparam logic [2:0] MODE_XPR  = 3'h2;
   localparam logic [2:0] MODE_RSVD = 3'h1;

   ////////////////////////////////////////////////////////////////////
   // Address, frame check and pad values
   localparam int          ADDR_W        = 18;
   localparam logic [17:0] ADDR_UP_START = 18'h0_0000;
   localparam logic [17:0] ADDR_DN_START = 18'h3_FFFF;
   localparam int          CHK_LSB       = 0;
   localparam logic [3:0]  CHECK_FIELD   = 4'h6;
   localparam logic [2:0]  PULL_ALL      = 3'h7;
   localparam logic [2:0]  PULL_NONE     = 3'h0;
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

   ////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_LOAD,
      ST_ERR,
      ST_BAD,
      ST_DONE
   } cml_state_t;

   typedef struct packed {
      logic       vld;
      logic [7:0] data;
   } cml_col_t;

   typedef struct packed {
      logic vld;
      logic val;
   } cml_bit_t;

   typedef struct packed {
      logic [2:0] o;
      logic [2:0] oe;
      logic [2:0] pu;
   } cml_pad_t;

   ////////////////////////////////////////////////////////////////////
   // Mode decoding used by the system clock domain
   function automatic logic cml_is_master(input logic [2:0] m);
      return m == MODE_MSER || m == MODE_MPUP || m == MODE_MPDN;
   endfunction : cml_is_master

   function automatic logic cml_clk_out(input logic [2:0] m);
      return cml_is_master(m) || m == MODE_APER;
   endfunction : cml_clk_out

   function automatic logic cml_is_slave(input logic [2:0] m);
      return m == MODE_SSER || m == MODE_SPER || m == MODE_XPR;
   endfunction : cml_is_slave

endpackage : cml_pkg

// ### cml_fifo.sv
`timescale 1ns/1ns
module cml_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         mclk_i,
   input  wire logic         rst_n_i,
   input  wire logic         in_vld_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_rdy_o,
   output logic              out_vld_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_rdy_i
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL_C = (AW+1)'(D);

   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          load;

   assign in_rdy_o = cnt_r != FULL_C;
   assign push     = in_vld_i && in_rdy_o;
   // Prefetch into the output register whenever it is free
   assign load     = (cnt_r != '0) && (!out_vld_o || out_rdy_i);

   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem[wp_r] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + AW'(1);
         end
         if (load) begin
            rp_r <= rp_r + AW'(1);
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_vld_o  <= 1'b0;
         out_data_o <= '0;
      end else if (load) begin
         out_vld_o  <= 1'b1;
         out_data_o <= mem[rp_r];
      end else if (out_rdy_i) begin
         out_vld_o  <= 1'b0;
      end
   end

endmodule : cml_fifo

// ### cml_loader.sv
`timescale 1ns/1ns
module cml_loader #(
   parameter int CLK_HALF    = cml_pkg::CONFIG_CLOCK_HALF_CYC,
   parameter int FRAME_BYTES = 4,
   parameter int NUM_FRAMES  = 16,
   parameter int FIFO_DEPTH  = 8
) (
   input  wire logic          mclk_i,
   input  wire logic          rst_n_i,
   input  wire logic          config_clock_i,
   input  wire logic          cfg_start_i,
   input  wire logic [2:0]    mode_select_i,
   input  wire logic [7:0]    data_i,
   input  wire logic          periph_wr_n_i,
   input  wire logic          crc_sel_i,
   input  wire logic [23:0]   length_count_i,
   input  wire logic [2:0]    aux_out_i,
   input  wire logic [2:0]    aux_oe_i,
   output logic               config_clock_o,
   output logic               config_clock_oe_o,
   output logic [17:0]        prom_addr_o,
   output cml_pkg::cml_pad_t  mode_pad_o,
   output logic [2:0]         aux_in_o,
   output logic [2:0]         mode_o,
   output logic               init_n_o,
   output logic               done_o,
   output logic               periph_busy_o,
   output cml_pkg::cml_bit_t  frame_bit_o,
   output cml_pkg::cml_col_t  column_o
);
   localparam int DW  = $clog2(CLK_HALF + 1);
   localparam int FBW = $clog2(FRAME_BYTES + 1);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers, system side
   logic [13:0] meta_r;
   logic [13:0] sync_r;
   logic [2:0]  prev_r;
   logic        s_tog, s_start, s_wr_n;
   logic [2:0]  s_mode;
   logic [7:0]  s_data;
   logic        start_rise, wr_fall, lk_evt;
   logic        lk_tog_r;
   logic [7:0]  lk_byte_r;

   assign {s_tog, s_start, s_wr_n, s_mode, s_data} = sync_r;
   assign start_rise = s_start & ~prev_r[2];
   assign wr_fall    = ~s_wr_n & prev_r[1];
   assign lk_evt     = s_tog ^ prev_r[0];

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end else begin
         meta_r <= {lk_tog_r, cfg_start_i, periph_wr_n_i,
                    mode_select_i, data_i};
         sync_r <= meta_r;
         prev_r <= {s_start, s_wr_n, s_tog};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer and captured mode
   cml_pkg::cml_state_t st_r;
   logic m_mser, m_par, m_dn, m_aper, m_xpr, m_slave, m_cko;
   logic fail, finish, done_st;

   assign m_mser  = mode_o == cml_pkg::MODE_MSER;
   assign m_par   = cml_pkg::cml_is_master(mode_o) && !m_mser;
   assign m_dn    = mode_o == cml_pkg::MODE_MPDN;
   assign m_aper  = mode_o == cml_pkg::MODE_APER;
   assign m_xpr   = mode_o == cml_pkg::MODE_XPR;
   assign m_slave = cml_pkg::cml_is_slave(mode_o);
   assign m_cko   = cml_pkg::cml_clk_out(mode_o);
   assign done_st = st_r == cml_pkg::ST_DONE;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= cml_pkg::ST_IDLE;
      end else begin
         case (st_r)
            cml_pkg::ST_IDLE, cml_pkg::ST_ERR,
            cml_pkg::ST_BAD, cml_pkg::ST_DONE: begin
               if (start_rise) begin
                  st_r <= cml_pkg::ST_SAMPLE;
               end
            end
            cml_pkg::ST_SAMPLE: begin
               // No loading on the reserved code
               if (s_mode == cml_pkg::MODE_RSVD) begin
                  st_r <= cml_pkg::ST_BAD;
               end else begin
                  st_r <= cml_pkg::ST_LOAD;
               end
            end
            cml_pkg::ST_LOAD: begin
               if (fail) begin
                  st_r <= cml_pkg::ST_ERR;
               end else if (finish) begin
                  st_r <= cml_pkg::ST_DONE;
               end
            end
            default: st_r <= cml_pkg::ST_IDLE;
         endcase
      end
   end

   // Undriven pins read high, so reset matches serial slave
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_o <= cml_pkg::MODE_SSER;
      end else if (st_r == cml_pkg::ST_SAMPLE) begin
         mode_o <= s_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Master clock, addresses and data capture
   logic [DW-1:0] div_r;
   logic [7:0]    msh_r;
   logic [2:0]    mbit_r;
   logic          run, tick, can, rise;
   logic          fifo_rdy;

   assign run  = (st_r == cml_pkg::ST_LOAD || st_r == cml_pkg::ST_ERR)
                 && m_cko;
   assign tick = div_r == DW'(CLK_HALF - 1);
   // Holding the clock low is the back-pressure towards the memory
   assign can  = fifo_rdy || m_aper || st_r != cml_pkg::ST_LOAD;
   assign rise = run && tick && !config_clock_o && can;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_r          <= '0;
         config_clock_o <= 1'b0;
      end else if (!run) begin
         div_r          <= '0;
         config_clock_o <= 1'b0;
      end else if (tick) begin
         div_r <= '0;
         if (config_clock_o) begin
            config_clock_o <= 1'b0;
         end else if (can) begin
            config_clock_o <= 1'b1;
         end
      end else begin
         div_r <= div_r + DW'(1);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prom_addr_o <= cml_pkg::ADDR_UP_START;
         msh_r       <= '0;
         mbit_r      <= '0;
      end else if (st_r == cml_pkg::ST_SAMPLE) begin
         mbit_r <= '0;
         if (s_mode == cml_pkg::MODE_MPDN) begin
            prom_addr_o <= cml_pkg::ADDR_DN_START;
         end else begin
            prom_addr_o <= cml_pkg::ADDR_UP_START;
         end
      end else if (rise && !m_aper) begin
         if (m_par && m_dn) begin
            prom_addr_o <= prom_addr_o - 18'h1;
         end else if (m_par || mbit_r == 3'h7) begin
            prom_addr_o <= prom_addr_o + 18'h1;
         end
         if (m_mser) begin
            msh_r  <= {s_data[0], msh_r[7:1]};
            mbit_r <= mbit_r + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Byte source select and buffer
   logic       push_v;
   logic [7:0] push_d;
   logic       q_v, q_rdy, pop, is_chk, chk_bad;
   logic [7:0] q_d;

   always_comb begin
      push_v = 1'b0;
      push_d = s_data;
      if (st_r == cml_pkg::ST_LOAD) begin
         if (m_par) begin
            push_v = rise;
         end else if (m_mser) begin
            push_v = rise && mbit_r == 3'h7;
            push_d = {s_data[0], msh_r[7:1]};
         end else if (m_aper) begin
            push_v = wr_fall;
         end else if (m_slave) begin
            push_v = lk_evt;
            push_d = lk_byte_r;
         end
      end
   end

   // Slave and peripheral sources cannot be stalled here
   assign fail = (push_v && !fifo_rdy) || chk_bad;

   cml_fifo #(
      .W (8),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .in_vld_i   (push_v),
      .in_data_i  (push_d),
      .in_rdy_o   (fifo_rdy),
      .out_vld_o  (q_v),
      .out_data_o (q_d),
      .out_rdy_i  (q_rdy)
   );

   ////////////////////////////////////////////////////////////////////
   // Frame check, length and column or bit output
   logic [FBW-1:0] fb_r;
   logic [15:0]    fr_r;
   logic [23:0]    byt_r;
   logic [3:0]     ser_n_r;
   logic [7:0]     ser_sh_r;

   assign q_rdy   = st_r == cml_pkg::ST_LOAD && ser_n_r == '0;
   assign pop     = q_v && q_rdy;
   assign is_chk  = fb_r == FBW'(FRAME_BYTES);
   assign chk_bad = pop && is_chk && (m_xpr || !crc_sel_i)
                    && q_d[cml_pkg::CHK_LSB +: 4] != cml_pkg::CHECK_FIELD;
   // Express ends on a full memory, others on the length count
   assign finish  = ser_n_r == '0 && (m_xpr ?
                    fr_r == 16'(NUM_FRAMES) :
                    byt_r == length_count_i);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fb_r  <= '0;
         fr_r  <= '0;
         byt_r <= '0;
      end else if (st_r == cml_pkg::ST_SAMPLE) begin
         fb_r  <= '0;
         fr_r  <= '0;
         byt_r <= '0;
      end else if (pop) begin
         byt_r <= byt_r + 24'h1;
         if (is_chk) begin
            fb_r <= '0;
            fr_r <= fr_r + 16'h1;
         end else begin
            fb_r <= fb_r + FBW'(1);
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         column_o    <= '0;
         frame_bit_o <= '0;
         ser_n_r     <= '0;
         ser_sh_r    <= '0;
      end else begin
         column_o.vld <= 1'b0;
         if (pop && !is_chk && m_xpr) begin
            column_o <= {1'b1, q_d};
         end
         if (ser_n_r != '0) begin
            frame_bit_o <= {1'b1, ser_sh_r[0]};
            ser_sh_r    <= {1'b0, ser_sh_r[7:1]};
            ser_n_r     <= ser_n_r - 4'h1;
         end else begin
            frame_bit_o.vld <= 1'b0;
            if (pop && !is_chk && !m_xpr) begin
               ser_sh_r <= q_d;
               ser_n_r  <= cml_pkg::BITS_PER_BYTE;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pads and status
   logic lk_arm_r;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         config_clock_oe_o <= 1'b0;
         init_n_o          <= 1'b1;
         done_o            <= 1'b0;
         periph_busy_o     <= 1'b1;
         lk_arm_r          <= 1'b0;
         aux_in_o          <= '0;
         mode_pad_o        <= {3'h0, 3'h0, cml_pkg::PULL_ALL};
      end else begin
         config_clock_oe_o <= run;
         init_n_o <= st_r != cml_pkg::ST_ERR
                     && st_r != cml_pkg::ST_BAD;
         done_o        <= done_st;
         periph_busy_o <= !(fifo_rdy && st_r == cml_pkg::ST_LOAD);
         lk_arm_r      <= st_r == cml_pkg::ST_LOAD && m_slave;
         mode_pad_o.pu <= done_st ? cml_pkg::PULL_NONE
                                  : cml_pkg::PULL_ALL;
         mode_pad_o.oe <= done_st ? aux_oe_i : 3'h0;
         mode_pad_o.o  <= done_st ? aux_out_i : 3'h0;
         aux_in_o      <= done_st ? s_mode : 3'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Link side: slave capture on the incoming configuration clock
   logic [3:0] lmeta_r;
   logic [3:0] lsync_r;
   logic       lk_first_r;
   logic [2:0] lk_bit_r;
   logic [7:0] lk_sh_r;

   always_ff @(posedge config_clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lmeta_r <= '0;
         lsync_r <= '0;
      end else begin
         lmeta_r <= {lk_arm_r, mode_o};
         lsync_r <= lmeta_r;
      end
   end

   // One byte per edge in parallel modes bar the first express edge, per eight edges in serial slave; crossing needs edges more than three system cycles apart
   always_ff @(posedge config_clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lk_first_r <= 1'b0;
         lk_bit_r   <= '0;
         lk_sh_r    <= '0;
         lk_byte_r  <= '0;
         lk_tog_r   <= 1'b0;
      end else if (!lsync_r[3]) begin
         lk_first_r <= 1'b0;
         lk_bit_r   <= '0;
      end else begin
         case (lsync_r[2:0])
            cml_pkg::MODE_SSER: begin
               lk_sh_r  <= {data_i[0], lk_sh_r[7:1]};
               lk_bit_r <= lk_bit_r + 3'h1;
               if (lk_bit_r == 3'h7) begin
                  lk_byte_r <= {data_i[0], lk_sh_r[7:1]};
                  lk_tog_r  <= ~lk_tog_r;
               end
            end
            cml_pkg::MODE_SPER: begin
               lk_byte_r <= data_i;
               lk_tog_r  <= ~lk_tog_r;
            end
            cml_pkg::MODE_XPR: begin
               lk_first_r <= 1'b1;
               if (lk_first_r) begin
                  lk_byte_r <= data_i;
                  lk_tog_r  <= ~lk_tog_r;
               end
            end
            default: lk_bit_r <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   property p_mode_cap;
      (st_r == cml_pkg::ST_SAMPLE) |=> mode_o == $past(s_mode);
   endproperty
   a_mode_cap: assert property (p_mode_cap)
      else $error("mode not captured from pins");

   property p_mode_hold;
      (st_r != cml_pkg::ST_SAMPLE) |=> $stable(mode_o);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("captured mode changed");

   property p_all_high;
      (st_r == cml_pkg::ST_SAMPLE && s_mode == 3'h7) |=>
         mode_o == cml_pkg::MODE_SSER && st_r == cml_pkg::ST_LOAD;
   endproperty
   a_all_high: assert property (p_all_high)
      else $error("all-high pins did not start serial slave");

   property p_rsvd;
      (st_r == cml_pkg::ST_SAMPLE && s_mode == cml_pkg::MODE_RSVD)
         |=> st_r == cml_pkg::ST_BAD ##1 !init_n_o && !done_o;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved code started loading");

   property p_pull;
      (st_r != cml_pkg::ST_DONE) |=> mode_pad_o.pu == 3'h7;
   endproperty
   a_pull: assert property (p_pull)
      else $error("mode pull-ups off during configuration");

   property p_aux;
      (st_r == cml_pkg::ST_DONE) |=> mode_pad_o.oe == $past(aux_oe_i);
   endproperty
   a_aux: assert property (p_aux)
      else $error("aux enable not passed after configuration");

   property p_dn_start;
      (st_r == cml_pkg::ST_SAMPLE && s_mode == cml_pkg::MODE_MPDN)
         |=> prom_addr_o == 18'h3_FFFF;
   endproperty
   a_dn_start: assert property (p_dn_start)
      else $error("down address did not start at top");

   property p_cko;
      (st_r == cml_pkg::ST_LOAD) |=> config_clock_oe_o == m_cko;
   endproperty
   a_cko: assert property (p_cko)
      else $error("clock direction wrong for mode");

   property p_ser8;
      $rose(frame_bit_o.vld) |-> frame_bit_o.vld [*8] ##1 !frame_bit_o.vld;
   endproperty
   a_ser8: assert property (p_ser8)
      else $error("byte not serialized as eight bits");

   property p_col;
      column_o.vld |-> m_xpr && !frame_bit_o.vld;
   endproperty
   a_col: assert property (p_col)
      else $error("column load outside express");

   property p_xchk;
      (pop && is_chk && m_xpr && q_d[3:0] != 4'h6) |=>
         st_r == cml_pkg::ST_ERR;
   endproperty
   a_xchk: assert property (p_xchk)
      else $error("express constant field error missed");

   property p_nolen;
      (st_r == cml_pkg::ST_LOAD && m_xpr && fr_r != 16'(NUM_FRAMES))
         |=> st_r != cml_pkg::ST_DONE;
   endproperty
   a_nolen: assert property (p_nolen)
      else $error("express finished before memory full");

   property p_err;
      (st_r == cml_pkg::ST_LOAD && fail) |=>
         st_r == cml_pkg::ST_ERR ##1 !init_n_o;
   endproperty
   a_err: assert property (p_err)
      else $error("frame error did not pull init low");

endmodule : cml_loader

// ### cml_prom_model.sv
`timescale 1ns/1ns
module cml_prom_model (
   input  wire logic [17:0] addr_i,
   output logic [7:0]       data_o
);
   ////////////////////////////////////////////////////////////////////
   // Asynchronous memory; data settles long before the 2FF sampling.
   // Content is a scramble of the address, so a stuck address shows.
   always_comb begin
      data_o = addr_i[7:0] ^ 8'h5A;
   end
endmodule : cml_prom_model

// ### tb.sv
`timescale 1ns/1ns
module tb;
   localparam int FB = 2;
   localparam int NF = 2;
   logic              mclk_i         = 1'b0;
   logic              rst_n_i        = 1'b0;
   logic              config_clock_i = 1'b0;
   logic              cfg_start_i    = 1'b0;
   logic [2:0]        mode_select_i  = 3'h7;
   logic [7:0]        xdata          = 8'h00;
   logic              periph_wr_n_i  = 1'b1;
   logic              use_prom       = 1'b0;
   logic              crc_sel_i      = 1'b0;
   logic [23:0]       length_count_i = 24'h00_0001;
   logic [2:0]        aux_out_i      = 3'h0;
   logic [2:0]        aux_oe_i       = 3'h0;
   logic [7:0]        prom_data;
   logic [7:0]        data_i;
   logic              config_clock_o;
   logic              config_clock_oe_o;
   logic [17:0]       prom_addr_o;
   cml_pkg::cml_pad_t mode_pad_o;
   logic [2:0]        aux_in_o;
   logic [2:0]        mode_o;
   logic              init_n_o;
   logic              done_o;
   logic              periph_busy_o;
   cml_pkg::cml_bit_t frame_bit_o;
   cml_pkg::cml_col_t column_o;
   int                bad_count = 0;
   int                tests_run = 0;
   int                cyc       = 0;
   int                fb_n      = 0;
   logic [7:0]        fb_sh     = 8'h00;
   logic [7:0]        col_q[$];
   logic [7:0]        exp_q[$];

   assign data_i = use_prom ? prom_data : xdata;
   always #50 mclk_i = ~mclk_i;

   // First master byte needs three cycles of settled data after the
   // start address, so two is too short a half period here
   cml_loader #(.CLK_HALF(3), .FRAME_BYTES(FB), .NUM_FRAMES(NF),
                .FIFO_DEPTH(8)) cml_loader_inst (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .config_clock_i(config_clock_i),
      .cfg_start_i(cfg_start_i), .mode_select_i(mode_select_i),
      .data_i(data_i), .periph_wr_n_i(periph_wr_n_i), .crc_sel_i(crc_sel_i),
      .length_count_i(length_count_i), .aux_out_i(aux_out_i),
      .aux_oe_i(aux_oe_i), .config_clock_o(config_clock_o),
      .config_clock_oe_o(config_clock_oe_o), .prom_addr_o(prom_addr_o),
      .mode_pad_o(mode_pad_o), .aux_in_o(aux_in_o), .mode_o(mode_o),
      .init_n_o(init_n_o), .done_o(done_o), .periph_busy_o(periph_busy_o),
      .frame_bit_o(frame_bit_o), .column_o(column_o));
   cml_prom_model cml_prom_model_inst (.addr_i(prom_addr_o),
                                       .data_o(prom_data));

   ////////////////////////////////////////////////////////////////////
   always @(posedge mclk_i) begin
      if (column_o.vld === 1'b1) col_q.push_back(column_o.data);
      // Keep only the first serialized byte of each run, LSB first
      if (rst_n_i !== 1'b1) begin
         fb_n <= 0;
      end else if (frame_bit_o.vld === 1'b1 && fb_n < 8) begin
         fb_sh <= {frame_bit_o.val, fb_sh[7:1]};
         fb_n  <= fb_n + 1;
      end
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic test_done();
      if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Fresh reset per run; ends one step after the mode is captured
   task automatic begin_cfg(input logic [2:0] m);
      @(posedge mclk_i) rst_n_i <= 1'b0;
      cfg_start_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      mode_select_i <= m;
      @(posedge mclk_i) cfg_start_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      #1;
      col_q.delete();
   endtask : begin_cfg

   task automatic wait_clk(input logic v);
      int n;
      n = 0;
      while (config_clock_o !== v && n < 40) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      chk(config_clock_o, v);
   endtask : wait_clk

   task automatic run_master(input logic [2:0] m, input logic [17:0] a0,
                             input logic dn);
      logic [17:0] e;
      use_prom = 1'b1;
      begin_cfg(m);
      chk(prom_addr_o, a0);
      @(posedge mclk_i) mode_select_i <= ~m;
      for (int k = 1; k < 3; k++) begin
         wait_clk(1'b0);
         wait_clk(1'b1);
         e = dn ? a0 - 18'(k) : a0 + 18'(k);
         chk(prom_addr_o, e);
      end
      chk(config_clock_oe_o, 1'b1);
      chk(mode_o, m);
      chk(periph_busy_o, 1'b0);
      repeat (8) @(posedge mclk_i);
      #1;
      chk(fb_sh, a0[7:0] ^ 8'h5A);
      chk(periph_busy_o, 1'b1);
   endtask : run_master

   // One 3 ns link clock pulse per byte, spaced for the crossing
   task automatic xpulse(input logic [7:0] b);
      @(posedge mclk_i) xdata <= b;
      #20 config_clock_i = 1'b1;
      #3 config_clock_i = 1'b0;
      repeat (6) @(posedge mclk_i);
   endtask : xpulse

   task automatic run_xpr(input logic [3:0] nib, input logic ok);
      logic [7:0] b;
      int         j;
      use_prom = 1'b0;
      crc_sel_i <= 1'b1;
      exp_q.delete();
      begin_cfg(cml_pkg::MODE_XPR);
      @(posedge mclk_i) mode_select_i <= 3'h6;
      for (int i = 0; i < 3 + NF * (FB + 1); i++) begin
         j = i - 3;
         b = 8'hFF;
         if (i >= 3 && j % (FB + 1) == FB) b = {4'hF, nib};
         else if (i >= 3) begin
            b = 8'(j * 19 + 1);
            exp_q.push_back(b);
         end
         xpulse(b);
      end
      repeat (20) @(posedge mclk_i);
      #1;
      chk(init_n_o, ok);
      chk(done_o, ok);
      chk(mode_o, cml_pkg::MODE_XPR);
      if (ok) begin
         chk(32'(col_q.size()), 32'(NF * FB));
         foreach (exp_q[k]) chk(col_q[k], exp_q[k]);
         chk(mode_pad_o.pu, cml_pkg::PULL_NONE);
         chk(aux_in_o, 3'h6);
         @(posedge mclk_i) aux_oe_i <= 3'h5;
         aux_out_i <= 3'h4;
         repeat (3) @(posedge mclk_i);
         #1;
         chk(mode_pad_o.oe, 3'h5);
         chk(mode_pad_o.o, 3'h4);
      end
   endtask : run_xpr

   ////////////////////////////////////////////////////////////////////
   initial begin
      logic [2:0] m;
      logic       e_oe;
      repeat (4) @(posedge mclk_i);
      #1;
      chk(mode_pad_o.pu, cml_pkg::PULL_ALL);
      chk(done_o, 1'b0);
      for (int c = 0; c < 8; c++) begin
         m = c[2:0];
         begin_cfg(m);
         chk(mode_o, m);
         repeat (2) @(posedge mclk_i);
         #1;
         e_oe = m == cml_pkg::MODE_MSER || m == cml_pkg::MODE_MPUP ||
                m == cml_pkg::MODE_MPDN || m == cml_pkg::MODE_APER;
         chk(config_clock_oe_o, 32'(e_oe));
         chk(init_n_o, 32'(m != 1));
         chk(mode_pad_o.pu, cml_pkg::PULL_ALL);
      end
      run_master(cml_pkg::MODE_MPUP, cml_pkg::ADDR_UP_START, 1'b0);
      run_master(cml_pkg::MODE_MPDN, cml_pkg::ADDR_DN_START, 1'b1);
      // One asynchronous peripheral write, length count of one byte
      use_prom = 1'b0;
      begin_cfg(cml_pkg::MODE_APER);
      @(posedge mclk_i) xdata <= 8'hC3;
      periph_wr_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      periph_wr_n_i <= 1'b1;
      repeat (14) @(posedge mclk_i);
      #1;
      chk(fb_sh, 8'hC3);
      chk(done_o, 1'b1);
      run_xpr(4'h6, 1'b1);
      run_xpr(4'h9, 1'b0);
      test_done();
   end
endmodule : tb
